/* logic/usfb_core.sv */
// Serial transceiver core: data port, error status, flags, baud divisor and line control.
`timescale 1ns/1ps
`default_nettype none
module usfb_core #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port.
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [11:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    // Serial line.
    input wire logic i_rxd,
    output logic o_txd
);
    import usfb_pkg::*;
    localparam int AW = $clog2(FIFO_DEPTH);

    logic [7:0] line_ctrl;
    logic [15:0] div_int_reg;
    logic [5:0] div_frac_reg;
    logic [15:0] div_int_act;
    logic [5:0] div_frac_act;
    logic div_pending;
    logic [3:0] rx_status;
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [11:0] rx_mem [FIFO_DEPTH];
    logic [AW:0] tx_cnt, rx_cnt;
    logic [AW-1:0] tx_rd, tx_wr, rx_rd, rx_wr;
    logic fen;
    logic [AW:0] cap;
    logic tx_full, rx_full;
    logic wr_data, rd_data, wr_line;
    logic tx_pop, rx_push;
    logic [11:0] rx_push_word;
    logic tick;
    logic rx_s1, rx_s2;
    logic [2:0] nbits;
    logic [2:0] pad_shift;

    assign fen = line_ctrl[LC_FEN];
    assign cap = fen ? (AW+1)'(FIFO_DEPTH) : (AW+1)'(1);
    assign tx_full = (tx_cnt == cap);
    assign rx_full = (rx_cnt == cap);
    assign wr_data = i_reg_wr && (i_reg_addr == OFS_DATA);
    assign rd_data = i_reg_rd && (i_reg_addr == OFS_DATA);
    assign wr_line = i_reg_wr && (i_reg_addr == OFS_LINE);
    assign nbits = 3'(5 + line_ctrl[LC_WORD_LENGTH_LO +: 2]);
    // An eight-bit word wraps nbits to zero, so this right alignment shift is zero as well.
    assign pad_shift = 3'd0 - nbits;

    // Registers written by software.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            line_ctrl <= LINE_RESET;
            div_int_reg <= DIV_INT_RESET;
            div_frac_reg <= DIV_FRAC_RESET;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == OFS_LINE)
                line_ctrl <= i_reg_wdata[7:0];
            if (i_reg_addr == OFS_DIV_INT)
                div_int_reg <= i_reg_wdata[15:0];
            if (i_reg_addr == OFS_DIV_FRAC)
                div_frac_reg <= i_reg_wdata[5:0];
        end
    end

    // Divisor staging; the live copy changes only between characters.
    logic tx_active, rx_active;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            div_int_act <= DIV_INT_RESET;
            div_frac_act <= DIV_FRAC_RESET;
            div_pending <= 1'b0;
        end
        else
        begin
            if (wr_line)
                div_pending <= 1'b1;
            if (div_pending && !tx_active && !rx_active && !wr_line)
            begin
                div_int_act <= div_int_reg;
                div_frac_act <= div_frac_reg;
                div_pending <= 1'b0;
            end
        end
    end

    // Fractional tick generator: period is divisor plus frac/64 clocks; a zero divisor ticks every clock.
    logic [15:0] tk_cnt;
    logic [5:0] tk_acc;
    logic [6:0] acc_sum;
    assign acc_sum = {1'b0, tk_acc} + {1'b0, div_frac_act};
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            tk_cnt <= 16'h0000;
            tk_acc <= 6'h00;
            tick <= 1'b0;
        end
        else if (div_int_act == 16'h0000)
            tick <= 1'b1;
        else if (tk_cnt == 16'h0000)
        begin
            tick <= 1'b1;
            tk_acc <= acc_sum[5:0];
            tk_cnt <= div_int_act - 16'h0001 + {15'h0000, acc_sum[6]};
        end
        else
        begin
            tick <= 1'b0;
            tk_cnt <= tk_cnt - 16'h0001;
        end
    end

    // Transmit FIFO.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            tx_cnt <= '0;
            tx_rd <= '0;
            tx_wr <= '0;
        end
        else
        begin
            if (wr_data && !tx_full)
            begin
                tx_mem[tx_wr] <= i_reg_wdata[7:0];
                tx_wr <= (fen && int'(tx_wr) != FIFO_DEPTH-1) ? tx_wr + 1'b1 : '0;
            end
            if (tx_pop)
                tx_rd <= (fen && int'(tx_rd) != FIFO_DEPTH-1) ? tx_rd + 1'b1 : '0;
            tx_cnt <= tx_cnt + (AW+1)'(wr_data && !tx_full) - (AW+1)'(tx_pop);
        end
    end

    // Transmitter: a two-entry skid stage sits between FIFO and shifter.
    logic [7:0] sk_data [2];
    logic [1:0] sk_cnt;
    logic sk_head;
    logic sk_ready;
    logic sh_take;
    assign sk_ready = (sk_cnt != 2'd2);
    assign tx_pop = (tx_cnt != '0) && sk_ready;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            sk_cnt <= 2'd0;
            sk_head <= 1'b0;
        end
        else
        begin
            if (tx_pop)
                // The free slot follows the stored entry even when the shifter takes one.
                sk_data[sk_head ^ (sk_cnt != 2'd0)] <= tx_mem[tx_rd];
            if (sh_take)
                sk_head <= ~sk_head;
            sk_cnt <= sk_cnt + 2'(tx_pop) - 2'(sh_take);
        end
    end

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} usfb_tx_t;
    usfb_tx_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_ovs;
    logic [2:0] tx_bit;
    logic tx_par;
    logic tx_stop2;
    assign tx_active = (tx_st != TX_IDLE);
    assign sh_take = (tx_st == TX_IDLE) && (sk_cnt != 2'd0) && !line_ctrl[LC_BRK];
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            tx_st <= TX_IDLE;
            o_txd <= 1'b1;
            tx_sh <= 8'h00;
            tx_ovs <= 4'h0;
            tx_bit <= 3'd0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
        end
        else
        begin
            unique case (tx_st)
                TX_IDLE:
                begin
                    o_txd <= ~line_ctrl[LC_BRK];
                    tx_ovs <= 4'h0;
                    if (sh_take)
                    begin
                        tx_sh <= sk_data[sk_head];
                        tx_par <= ^(sk_data[sk_head] & (8'hFF >> pad_shift)) ^ ~line_ctrl[LC_EPS];
                        tx_st <= TX_START;
                        o_txd <= 1'b0;
                    end
                end
                TX_START:
                    if (tick)
                    begin
                        tx_ovs <= tx_ovs + 4'h1;
                        if (tx_ovs == OVS_LAST)
                        begin
                            tx_st <= TX_DATA;
                            tx_bit <= 3'd0;
                            o_txd <= tx_sh[0];
                        end
                    end
                TX_DATA:
                    if (tick)
                    begin
                        tx_ovs <= tx_ovs + 4'h1;
                        if (tx_ovs == OVS_LAST)
                        begin
                            tx_sh <= {1'b0, tx_sh[7:1]};
                            tx_bit <= tx_bit + 3'd1;
                            if (tx_bit == nbits - 3'd1)
                            begin
                                tx_st <= line_ctrl[LC_PEN] ? TX_PAR : TX_STOP;
                                o_txd <= !line_ctrl[LC_PEN] ? 1'b1 :
                                    line_ctrl[LC_SPS] ? ~line_ctrl[LC_EPS] : tx_par;
                                tx_stop2 <= line_ctrl[LC_TWO_STOP_SEL];
                            end
                            else
                                o_txd <= tx_sh[1];
                        end
                    end
                TX_PAR:
                    if (tick)
                    begin
                        tx_ovs <= tx_ovs + 4'h1;
                        if (tx_ovs == OVS_LAST)
                        begin
                            tx_st <= TX_STOP;
                            o_txd <= 1'b1;
                        end
                    end
                TX_STOP:
                    if (tick)
                    begin
                        tx_ovs <= tx_ovs + 4'h1;
                        if (tx_ovs == OVS_LAST)
                        begin
                            if (tx_stop2)
                                tx_stop2 <= 1'b0;
                            else
                                tx_st <= TX_IDLE;
                        end
                    end
            endcase
        end
    end

    // Receiver.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end
        else
        begin
            rx_s1 <= i_rxd;
            rx_s2 <= rx_s1;
        end
    end

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} usfb_rx_t;
    usfb_rx_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_ovs;
    logic [2:0] rx_bit;
    logic rx_perr;
    logic rx_allzero;
    logic overrun_evt;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rx_st <= RX_IDLE;
            rx_sh <= 8'h00;
            rx_ovs <= 4'h0;
            rx_bit <= 3'd0;
            rx_perr <= 1'b0;
            rx_allzero <= 1'b1;
            rx_push <= 1'b0;
            rx_push_word <= 12'h000;
        end
        else
        begin
            rx_push <= 1'b0;
            if (rx_st != RX_IDLE && rx_st != RX_WAIT && tick)
                rx_ovs <= rx_ovs + 4'h1;
            unique case (rx_st)
                RX_IDLE:
                    if (!rx_s2)
                    begin
                        rx_st <= RX_START;
                        rx_ovs <= 4'h0;
                        rx_allzero <= 1'b1;
                        rx_perr <= 1'b0;
                    end
                RX_START:
                    if (tick && rx_ovs == OVS_MID)
                    begin
                        rx_ovs <= 4'h0;
                        rx_bit <= 3'd0;
                        rx_st <= rx_s2 ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (tick && rx_ovs == OVS_LAST)
                    begin
                        rx_sh <= {rx_s2, rx_sh[7:1]};
                        rx_allzero <= rx_allzero & ~rx_s2;
                        rx_bit <= rx_bit + 3'd1;
                        if (rx_bit == nbits - 3'd1)
                            rx_st <= line_ctrl[LC_PEN] ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (tick && rx_ovs == OVS_LAST)
                    begin
                        rx_allzero <= rx_allzero & ~rx_s2;
                        if (line_ctrl[LC_SPS])
                            rx_perr <= rx_s2 ^ ~line_ctrl[LC_EPS];
                        else
                            rx_perr <= ^(rx_sh >> pad_shift) ^ rx_s2
                                ^ ~line_ctrl[LC_EPS];
                        rx_st <= RX_STOP;
                    end
                RX_STOP:
                    if (tick && rx_ovs == OVS_LAST)
                    begin
                        rx_push <= 1'b1;
                        if (rx_allzero && !rx_s2)
                        begin
                            rx_push_word <= 12'h400;
                            rx_st <= RX_WAIT;
                        end
                        else
                        begin
                            rx_push_word <= {2'b00, rx_perr, ~rx_s2,
                                rx_sh >> pad_shift};
                            rx_st <= rx_s2 ? RX_IDLE : RX_WAIT;
                        end
                    end
                RX_WAIT:
                    if (rx_s2)
                        rx_st <= RX_IDLE;
                default:
                    rx_st <= RX_IDLE;
            endcase
        end
    end
    assign rx_active = (rx_st != RX_IDLE) && (rx_st != RX_WAIT);

    // Receive FIFO.
    logic rx_pop;
    assign rx_pop = rd_data && (rx_cnt != '0);
    assign overrun_evt = rx_push && rx_full && !rx_pop;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rx_cnt <= '0;
            rx_rd <= '0;
            rx_wr <= '0;
        end
        else
        begin
            if (rx_push && !overrun_evt)
            begin
                rx_mem[rx_wr] <= rx_push_word;
                rx_wr <= (fen && int'(rx_wr) != FIFO_DEPTH-1) ? rx_wr + 1'b1 : '0;
            end
            if (rx_pop)
                rx_rd <= (fen && int'(rx_rd) != FIFO_DEPTH-1) ? rx_rd + 1'b1 : '0;
            rx_cnt <= rx_cnt + (AW+1)'(rx_push && !overrun_evt) - (AW+1)'(rx_pop);
        end
    end

    // Error status and read data.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            rx_status <= 4'h0;
        else
        begin
            if (rx_pop)
                rx_status[2:0] <= rx_mem[rx_rd][10:8];
            if (i_reg_wr && i_reg_addr == OFS_STATUS)
                rx_status <= 4'h0;
            if (overrun_evt)
                rx_status[ERR_OE] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            o_reg_rdata <= 32'h0000_0000;
        else if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                OFS_DATA:
                    o_reg_rdata <= (rx_cnt != '0) ?
                        {20'h00000, rx_status[ERR_OE], rx_mem[rx_rd][10:0]} : 32'h0;
                OFS_STATUS:
                    o_reg_rdata <= {28'h0000000, rx_status};
                OFS_FLAGS:
                    o_reg_rdata <= {24'h000000, tx_cnt == '0, rx_full, tx_full,
                        rx_cnt == '0,
                        (tx_cnt != '0) || (sk_cnt != 2'd0) || tx_active, 3'b000};
                OFS_DIV_INT:
                    o_reg_rdata <= {16'h0000, div_int_reg};
                OFS_DIV_FRAC:
                    o_reg_rdata <= {26'h0000000, div_frac_reg};
                OFS_LINE:
                    o_reg_rdata <= {24'h000000, line_ctrl};
                default:
                    o_reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    overrun_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        overrun_evt |=> rx_status[ERR_OE] && rx_cnt == $past(rx_cnt))
        else $error("overrun changed fifo");
    err_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == OFS_STATUS && !overrun_evt) |=> rx_status == 4'h0)
        else $error("error clear failed");
    send_brk_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (line_ctrl[LC_BRK] && tx_st == TX_IDLE) [*2] |-> !o_txd)
        else $error("break not driven");
    hold_depth_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !fen |-> tx_cnt <= 1 && rx_cnt <= 1)
        else $error("holding register overfilled");
    div_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tx_active || rx_active) |=> $stable(div_int_act) && $stable(div_frac_act))
        else $error("divisor changed inside a character");
    stop_level_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        tx_st == TX_STOP |-> o_txd)
        else $error("stop bit not high");
endmodule
`default_nettype wire

/* logic/usfb_pkg.sv */
// Package of register offsets, field positions and timing constants for the serial core.
package usfb_pkg;
    localparam logic [11:0] OFS_DATA = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h018;
    localparam logic [11:0] OFS_DIV_INT = 12'h024;
    localparam logic [11:0] OFS_DIV_FRAC = 12'h028;
    localparam logic [11:0] OFS_LINE = 12'h02C;
    localparam int LC_BRK = 0;
    localparam int LC_PEN = 1;
    localparam int LC_EPS = 2;
    localparam int LC_TWO_STOP_SEL = 3;
    localparam int LC_FEN = 4;
    localparam int LC_WORD_LENGTH_LO = 5;
    localparam int LC_SPS = 7;
    localparam int FL_BUSY = 3;
    localparam int FL_RX_EMPTY_FLAG = 4;
    localparam int FL_TX_FULL_FLAG = 5;
    localparam int FL_RX_FULL_FLAG = 6;
    localparam int FL_TX_EMPTY_FLAG = 7;
    localparam int ERR_FE = 0;
    localparam int ERR_PE = 1;
    localparam int ERR_BE = 2;
    localparam int ERR_OE = 3;
    localparam logic [7:0] LINE_RESET = 8'h00;
    localparam logic [15:0] DIV_INT_RESET = 16'h0000;
    localparam logic [5:0] DIV_FRAC_RESET = 6'h00;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;
endpackage

/* tb/usfb_remote.sv */
// Remote serial device model that sends frames to the core and captures its frames.
`timescale 1ns/1ps
`default_nettype none
module usfb_remote #(
    parameter int BIT_CLKS = 16
) (
    // Clock.
    input wire logic i_clk_sys,
    // Serial line.
    input wire logic i_txd,
    output logic o_rxd
);
    initial o_rxd = 1'b1;

    // Start bit, data LSB first, optional parity, chosen stop level, then two idle bit times.
    task automatic send(input logic [7:0] d, input int nb, input logic parity_enable, input logic par,
                        input logic stp);
        logic q[$];
        q.push_back(1'b0);
        for (int i = 0; i < nb; i++)
            q.push_back(d[i]);
        if (parity_enable)
            q.push_back(par);
        q.push_back(stp);
        q.push_back(1'b1);
        q.push_back(1'b1);
        foreach (q[i])
        begin
            @(posedge i_clk_sys);
            #1;
            o_rxd = q[i];
            repeat (BIT_CLKS - 1) @(posedge i_clk_sys);
        end
    endtask

    // Holds the line low for a break, then returns it to the marking level.
    task automatic hold_low(input int clks);
        @(posedge i_clk_sys);
        #1;
        o_rxd = 1'b0;
        repeat (clks) @(posedge i_clk_sys);
        #1;
        o_rxd = 1'b1;
        repeat (4 * BIT_CLKS) @(posedge i_clk_sys);
    endtask

    // Samples each bit in its middle; the wait for a start bit is bounded so a dead line shows X.
    task automatic capture(input int nb, output logic [7:0] d, output logic [1:0] stp);
        int n;
        d = 8'hXX;
        stp = 2'bXX;
        n = 0;
        while (i_txd !== 1'b0 && n < 3000)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        if (n < 3000)
        begin
            d = 8'h00;
            repeat (BIT_CLKS / 2) @(posedge i_clk_sys);
            for (int i = 0; i < nb; i++)
            begin
                repeat (BIT_CLKS) @(posedge i_clk_sys);
                d[i] = i_txd;
            end
            for (int i = 0; i < 2; i++)
            begin
                repeat (BIT_CLKS) @(posedge i_clk_sys);
                stp[i] = i_txd;
            end
        end
    endtask
endmodule
`default_nettype wire

/* tb/uart_status_flags_baud_line_ctrl_tb_top.sv */
// Testbench for the serial core: register calls with expected values against a remote model.
`timescale 1ns/1ps
`default_nettype none
module uart_status_flags_baud_line_ctrl_tb_top;
    import usfb_pkg::*;
    localparam int DEPTH = 4;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [11:0] i_reg_addr = 12'h000;
    logic [31:0] i_reg_wdata = 32'h0000_0000;
    logic [31:0] o_reg_rdata;
    logic rxd;
    logic txd;
    logic [31:0] rd;
    logic [7:0] cap;
    logic [1:0] stp;
    logic [7:0] d;
    int n_mismatch = 0;
    int total_checks = 0;

    usfb_core #(.FIFO_DEPTH(DEPTH)) i_dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_rxd(rxd), .o_txd(txd)
    );
    usfb_remote i_remote (.i_clk_sys(i_clk_sys), .i_txd(txd), .o_rxd(rxd));

    initial
    begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        #1;
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = v;
        @(posedge i_clk_sys);
        #1;
        i_reg_wr = 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        #1;
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(posedge i_clk_sys);
        #1;
        i_reg_rd = 1'b0;
        @(posedge i_clk_sys);
        #1;
        v = o_reg_rdata;
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge i_clk_sys);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        rdr(OFS_FLAGS, rd); check(rd, 32'h0000_0090, "flags at reset");
        rdr(OFS_STATUS, rd); check(rd, 32'h0, "status at reset");
        rdr(OFS_DIV_FRAC, rd); check(rd, 32'h0, "fraction at reset");
        wr(OFS_DIV_INT, 32'hFFFF_1234);
        rdr(OFS_DIV_INT, rd); check(rd, 32'h0000_1234, "integer field");
        wr(OFS_DIV_FRAC, 32'h0000_00FF);
        rdr(OFS_DIV_FRAC, rd); check(rd, 32'h0000_003F, "fraction field");
        // Integer zero with a nonzero fraction must still give sixteen clocks a bit.
        wr(OFS_DIV_INT, 32'h0);
        wr(OFS_LINE, 32'h60);
        rdr(OFS_LINE, rd); check(rd, 32'h60, "line readback");
        wr(OFS_DATA, 32'h0000_01A5);
        rdr(OFS_FLAGS, rd); check(rd[FL_BUSY], 1'b1, "busy on queue");
        i_remote.capture(8, cap, stp); check(cap, 8'hA5, "tx byte");
        check(stp[0], 1'b1, "tx stop");
        repeat (40) @(posedge i_clk_sys);
        rdr(OFS_FLAGS, rd); check(rd, 32'h90, "idle flags");
        wr(OFS_LINE, 32'h0A);
        wr(OFS_DATA, 32'h13);
        i_remote.capture(6, cap, stp); check(cap, 8'h13, "five bits odd parity");
        check(stp, 2'b11, "two stops");
        // The capture returns inside the second stop bit, so the shifter is still busy.
        rdr(OFS_FLAGS, rd); check(rd[FL_BUSY], 1'b1, "busy in stop");
        repeat (40) @(posedge i_clk_sys);
        wr(OFS_LINE, 32'h61);
        repeat (20) @(posedge i_clk_sys);
        #1;
        check({31'h0, txd}, 32'h0, "break line low");
        wr(OFS_LINE, 32'h60);
        repeat (2) @(posedge i_clk_sys);
        #1;
        check({31'h0, txd}, 32'h1, "break released");
        for (int wl = 0; wl < 4; wl++)
        begin
            wr(OFS_LINE, 32'(wl << 5) | 32'h06);
            d = 8'hB6 & 8'(9'h1FF >> (4 - wl));
            i_remote.send(d, 5 + wl, 1'b1, ^d, 1'b1);
            rdr(OFS_DATA, rd); check(rd, {24'h0, d}, "word length rx");
        end
        i_remote.send(8'hB6, 8, 1'b1, ~^8'hB6, 1'b1);
        rdr(OFS_DATA, rd); check(rd, 32'h2B6, "parity error");
        rdr(OFS_STATUS, rd); check(rd, 32'h2, "status parity");
        wr(OFS_STATUS, 32'h0);
        rdr(OFS_STATUS, rd); check(rd, 32'h0, "status cleared");
        wr(OFS_LINE, 32'hE6);
        i_remote.send(8'h01, 8, 1'b1, 1'b0, 1'b1);
        rdr(OFS_DATA, rd); check(rd, 32'h01, "stick zero");
        wr(OFS_LINE, 32'hE2);
        i_remote.send(8'h01, 8, 1'b1, 1'b1, 1'b1);
        rdr(OFS_DATA, rd); check(rd, 32'h01, "stick one");
        wr(OFS_LINE, 32'h60);
        i_remote.send(8'h5A, 8, 1'b0, 1'b0, 1'b0);
        rdr(OFS_DATA, rd); check(rd, 32'h15A, "framing");
        rdr(OFS_STATUS, rd); check(rd, 32'h1, "status framing");
        i_remote.hold_low(540);
        rdr(OFS_DATA, rd); check(rd, 32'h400, "break char");
        rdr(OFS_DATA, rd); check(rd, 32'h0, "single break char");
        i_remote.send(8'h33, 8, 1'b0, 1'b0, 1'b1);
        rdr(OFS_DATA, rd); check(rd, 32'h033, "after break");
        wr(OFS_STATUS, 32'h0000_00FF);
        i_remote.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
        i_remote.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
        rdr(OFS_FLAGS, rd); check(rd & 32'h50, 32'h40, "holding full");
        rdr(OFS_STATUS, rd); check(rd, 32'h8, "overrun now");
        rdr(OFS_DATA, rd); check(rd, 32'h811, "first kept");
        rdr(OFS_FLAGS, rd); check(rd & 32'h50, 32'h10, "holding empty");
        wr(OFS_STATUS, 32'h0);
        wr(OFS_LINE, 32'h70);
        for (int i = 1; i <= DEPTH + 1; i++)
            i_remote.send(8'(8'h40 + i), 8, 1'b0, 1'b0, 1'b1);
        rdr(OFS_FLAGS, rd); check(rd & 32'h50, 32'h40, "fifo full");
        rdr(OFS_STATUS, rd); check(rd, 32'h8, "fifo overrun");
        for (int i = 1; i <= DEPTH; i++)
        begin
            rdr(OFS_DATA, rd); check(rd, 32'h800 | 32'(8'h40 + i), "fifo order");
        end
        rdr(OFS_FLAGS, rd); check(rd & 32'h50, 32'h10, "fifo empty");
        rdr(12'h100, rd); check(rd, 32'h0, "unmapped");
        final_report();
    end
endmodule
`default_nettype wire
